/* File: rtl/gpfa_cfg.svh */
`ifndef GPFA_CFG_SVH
`define GPFA_CFG_SVH
`define GPFA_OFF_DRIVE    8'h00
`define GPFA_OFF_OUTPUT   8'h04
`define GPFA_OFF_INPUT    8'h08
`define GPFA_OFF_FLAGS    8'h0c
`define GPFA_OFF_MASK     8'h10
`define GPFA_OFF_SENSE_LO 8'h14
`define GPFA_OFF_SENSE_HI 8'h18
`define GPFA_OFF_SWAP     8'h1c
`define GPFA_RST_BYTE     8'h00
`define GPFA_SYNC_STAGES  2
`endif

/* File: rtl/gpfa_pkg.sv */
package gpfa_pkg;
  typedef enum logic [2:0] {
    SENSE_NONE = 3'h0, SENSE_ANY = 3'h1, SENSE_RISE = 3'h2,
    SENSE_FALL = 3'h3, SENSE_OFF = 3'h4, SENSE_LOW = 3'h5
  } gpfa_sense_t;
  typedef struct packed {
    logic [31:0] data;
    logic        valid;
  } gpfa_rd_t;
endpackage

/* File: rtl/gpfa_pin_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module gpfa_pin_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinSync
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } gpfa_sync_st_t;
  gpfa_sync_st_t st_r;
  gpfa_sync_st_t st_nxt;

  always_comb begin
    st_nxt.meta = pinIn;
    st_nxt.sync = st_r.meta;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pinSync = st_r.sync;
endmodule // gpfa_pin_sync
`default_nettype wire

/* File: rtl/gpfa_port.sv */
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "gpfa_cfg.svh"
module gpfa_port #(
  parameter int PINS = 8
) (
  input  wire logic            clock,
  input  wire logic            rst,
  input  wire logic [7:0]      s_axi_awaddr,
  input  wire logic            s_axi_awvalid,
  output logic                 s_axi_awready,
  input  wire logic [31:0]     s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  input  wire logic            s_axi_wvalid,
  output logic                 s_axi_wready,
  output logic [1:0]           s_axi_bresp,
  output logic                 s_axi_bvalid,
  input  wire logic            s_axi_bready,
  input  wire logic [7:0]      s_axi_araddr,
  input  wire logic            s_axi_arvalid,
  output logic                 s_axi_arready,
  output logic [31:0]          s_axi_rdata,
  output logic [1:0]           s_axi_rresp,
  output logic                 s_axi_rvalid,
  input  wire logic            s_axi_rready,
  input  wire logic [PINS-1:0] pinIn,
  output logic      [PINS-1:0] pinOut,
  output logic      [PINS-1:0] pinOe,
  output logic                 portIrq
);
  initial begin
    if (PINS != 8) $error("gpfa_port serves exactly eight pins");
  end

  //--------------------------------------------------------------
  // State
  //--------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  driveEnable;
    logic [7:0]  outputLevel;
    logic [7:0]  inputLevel;
    logic [7:0]  eventFlags;
    logic [7:0]  eventMask;
    logic [23:0] senseSel;
    logic [7:0]  polSwap;
    logic [7:0]  prevIn;
    logic        awHeld;
    logic [7:0]  awAddr;
    logic        wHeld;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        bValid;
    logic [1:0]  bResp;
    gpfa_pkg::gpfa_rd_t rd;
    logic [1:0]  rResp;
  } gpfa_st_t;
  gpfa_st_t st_r;
  gpfa_st_t st_nxt;

  logic [7:0] pinSync;
  logic [7:0] pinLogic;
  logic [7:0] bufOn;
  logic [7:0] evHit;

  function automatic gpfa_pkg::gpfa_sense_t senseOf(input logic [23:0] s, input int n);
    return gpfa_pkg::gpfa_sense_t'(s[n*3 +: 3]);
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a == `GPFA_OFF_DRIVE || a == `GPFA_OFF_OUTPUT || a == `GPFA_OFF_INPUT ||
           a == `GPFA_OFF_FLAGS || a == `GPFA_OFF_MASK || a == `GPFA_OFF_SENSE_LO ||
           a == `GPFA_OFF_SENSE_HI || a == `GPFA_OFF_SWAP;
  endfunction

  //--------------------------------------------------------------
  // Pin input path
  //--------------------------------------------------------------
  gpfa_pin_sync #(.WIDTH(PINS)) u_sync (
    .clock   (clock),
    .rst     (rst),
    .pinIn   (pinIn),
    .pinSync (pinSync)
  );

  always_comb begin
    pinLogic = pinSync ^ st_r.polSwap;
    for (int n = 0; n < 8; n++) begin
      bufOn[n] = senseOf(st_r.senseSel, n) != gpfa_pkg::SENSE_OFF;
      unique case (senseOf(st_r.senseSel, n))
        gpfa_pkg::SENSE_ANY:  evHit[n] = pinLogic[n] != st_r.prevIn[n];
        gpfa_pkg::SENSE_RISE: evHit[n] = pinLogic[n] & ~st_r.prevIn[n];
        gpfa_pkg::SENSE_FALL: evHit[n] = ~pinLogic[n] & st_r.prevIn[n];
        gpfa_pkg::SENSE_LOW:  evHit[n] = ~pinLogic[n];
        default:              evHit[n] = 1'b0;
      endcase
    end
  end

  //--------------------------------------------------------------
  // Register and bus logic
  //--------------------------------------------------------------
  logic doWrite;
  logic doRead;
  logic [31:0] wMask;

  always_comb begin
    st_nxt  = st_r;
    doWrite = st_r.awHeld && st_r.wHeld && !st_r.bValid;
    doRead  = s_axi_arvalid && !st_r.rd.valid;
    wMask   = {{8{st_r.wStrb[3]}}, {8{st_r.wStrb[2]}}, {8{st_r.wStrb[1]}}, {8{st_r.wStrb[0]}}};

    st_nxt.prevIn = pinLogic;
    for (int n = 0; n < 8; n++) begin
      if (bufOn[n]) st_nxt.inputLevel[n] = pinLogic[n];
    end

    if (s_axi_awvalid && !st_r.awHeld) begin
      st_nxt.awHeld = 1'b1;
      st_nxt.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_r.wHeld) begin
      st_nxt.wHeld = 1'b1;
      st_nxt.wData = s_axi_wdata;
      st_nxt.wStrb = s_axi_wstrb;
    end

    if (doWrite) begin
      st_nxt.awHeld = 1'b0;
      st_nxt.wHeld  = 1'b0;
      st_nxt.bValid = 1'b1;
      st_nxt.bResp  = mapped(st_r.awAddr) ? 2'h0 : 2'h2;
      if (st_r.wStrb[0]) begin
        unique case (st_r.awAddr)
          `GPFA_OFF_DRIVE:  st_nxt.driveEnable = st_r.wData[7:0];
          `GPFA_OFF_OUTPUT: st_nxt.outputLevel = st_r.wData[7:0];
          `GPFA_OFF_INPUT:  st_nxt.outputLevel = st_r.outputLevel ^ st_r.wData[7:0];
          `GPFA_OFF_FLAGS:  st_nxt.eventFlags = st_r.eventFlags & ~st_r.wData[7:0];
          `GPFA_OFF_MASK:   st_nxt.eventMask = st_r.wData[7:0];
          `GPFA_OFF_SWAP:   st_nxt.polSwap = st_r.wData[7:0];
          default: ;
        endcase
      end
      if (st_r.awAddr == `GPFA_OFF_SENSE_LO) begin
        st_nxt.senseSel[11:0] = (st_r.senseSel[11:0] & ~wMask[11:0]) | (st_r.wData[11:0] & wMask[11:0]);
      end
      if (st_r.awAddr == `GPFA_OFF_SENSE_HI) begin
        st_nxt.senseSel[23:12] = (st_r.senseSel[23:12] & ~wMask[11:0]) | (st_r.wData[11:0] & wMask[11:0]);
      end
    end
    if (st_r.bValid && s_axi_bready) st_nxt.bValid = 1'b0;

    // Set wins over a same-cycle clear
    st_nxt.eventFlags = st_nxt.eventFlags | evHit;

    if (doRead) begin
      st_nxt.rd.valid = 1'b1;
      st_nxt.rResp    = mapped(s_axi_araddr) ? 2'h0 : 2'h2;
      unique case (s_axi_araddr)
        `GPFA_OFF_DRIVE:    st_nxt.rd.data = {24'h000000, st_r.driveEnable};
        `GPFA_OFF_OUTPUT:   st_nxt.rd.data = {24'h000000, st_r.outputLevel};
        `GPFA_OFF_INPUT:    st_nxt.rd.data = {24'h000000, st_r.inputLevel};
        `GPFA_OFF_FLAGS:    st_nxt.rd.data = {24'h000000, st_r.eventFlags};
        `GPFA_OFF_MASK:     st_nxt.rd.data = {24'h000000, st_r.eventMask};
        `GPFA_OFF_SENSE_LO: st_nxt.rd.data = {20'h00000, st_r.senseSel[11:0]};
        `GPFA_OFF_SENSE_HI: st_nxt.rd.data = {20'h00000, st_r.senseSel[23:12]};
        `GPFA_OFF_SWAP:     st_nxt.rd.data = {24'h000000, st_r.polSwap};
        default:            st_nxt.rd.data = 32'h00000000;
      endcase
    end else if (st_r.rd.valid && s_axi_rready) begin
      st_nxt.rd.valid = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  //--------------------------------------------------------------
  // Outputs
  //--------------------------------------------------------------
  assign s_axi_awready = !st_r.awHeld;
  assign s_axi_wready  = !st_r.wHeld;
  assign s_axi_bvalid  = st_r.bValid;
  assign s_axi_bresp   = st_r.bResp;
  assign s_axi_arready = !st_r.rd.valid;
  assign s_axi_rvalid  = st_r.rd.valid;
  assign s_axi_rdata   = st_r.rd.data;
  assign s_axi_rresp   = st_r.rResp;
  assign pinOe   = st_r.driveEnable;
  assign pinOut  = (st_r.outputLevel ^ st_r.polSwap) & st_r.driveEnable;
  assign portIrq = |(st_r.eventFlags & st_r.eventMask);

  //--------------------------------------------------------------
  // Checks
  //--------------------------------------------------------------
  chk_oe_follows: assert property (@(posedge clock) disable iff (rst)
    pinOe == st_r.driveEnable) else $error("pin enable differs from drive enable");
  chk_out_gated: assert property (@(posedge clock) disable iff (rst)
    (pinOut & ~pinOe) == 8'h00) else $error("pin driven while disabled");
  chk_out_level: assert property (@(posedge clock) disable iff (rst)
    ((pinOut ^ st_r.polSwap ^ st_r.outputLevel) & pinOe) == 8'h00) else $error("pin level wrong");
  chk_toggle_out: assert property (@(posedge clock) disable iff (rst)
    doWrite && st_r.awAddr == `GPFA_OFF_INPUT && st_r.wStrb[0]
    |=> st_r.outputLevel == ($past(st_r.outputLevel) ^ $past(st_r.wData[7:0])))
    else $error("toggle write wrong");
  chk_hold_input: assert property (@(posedge clock) disable iff (rst)
    senseOf(st_r.senseSel, 0) == gpfa_pkg::SENSE_OFF |=> $stable(st_r.inputLevel[0]))
    else $error("input sampled while buffer off");
  chk_sample_input: assert property (@(posedge clock) disable iff (rst)
    bufOn[0] |=> st_r.inputLevel[0] == $past(pinLogic[0])) else $error("input not sampled");
  chk_low_level: assert property (@(posedge clock) disable iff (rst)
    senseOf(st_r.senseSel, 0) == gpfa_pkg::SENSE_LOW && !pinLogic[0] |=> st_r.eventFlags[0])
    else $error("low level flag missing");
  chk_rise_flag: assert property (@(posedge clock) disable iff (rst)
    senseOf(st_r.senseSel, 1) == gpfa_pkg::SENSE_RISE && pinLogic[1] && !st_r.prevIn[1]
    |=> st_r.eventFlags[1]) else $error("rising edge flag missing");
  chk_flag_clear: assert property (@(posedge clock) disable iff (rst)
    doWrite && st_r.awAddr == `GPFA_OFF_FLAGS && st_r.wStrb[0] && st_r.wData[2] && !evHit[2]
    |=> !st_r.eventFlags[2]) else $error("flag not cleared");
  chk_irq_level: assert property (@(posedge clock) disable iff (rst)
    portIrq == |(st_r.eventFlags & st_r.eventMask)) else $error("irq mismatch");
  cov_write: cover property (@(posedge clock) doWrite);
  cov_read: cover property (@(posedge clock) s_axi_rvalid && s_axi_rready);
  cov_irq: cover property (@(posedge clock) $rose(portIrq));
endmodule // gpfa_port
`default_nettype wire

/* File: sim/gpfa_pin_model.sv */
`timescale 1ns/10ps
`default_nettype none
module gpfa_pin_model (
  input  wire logic [7:0] pinOut,
  input  wire logic [7:0] pinOe,
  input  wire logic [7:0] extLevel,
  output logic      [7:0] pinIn
);
  // A driven pin reads back its own level; an undriven pin follows the board
  assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
endmodule // gpfa_pin_model
`default_nettype wire

/* File: sim/gpio_port_fast_alias_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module gpio_port_fast_alias_tb;
  logic        clock = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0]  awaddr = 0, araddr = 0, ext = 0, d, o, t, v;
  logic [31:0] wdata = 0;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [7:0]  pinIn, pinOut, pinOe;
  logic [33:0] expQ[$];
  int          fail_count = 0, checks = 0;
  gpfa_port uut (.clock(clock), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pinIn(pinIn),
    .pinOut(pinOut), .pinOe(pinOe), .portIrq(irq));
  gpfa_pin_model pins (.pinOut(pinOut), .pinOe(pinOe), .extLevel(ext), .pinIn(pinIn));
  initial begin
    forever #20 clock = ~clock;
  end
  // ----------------------------------------
  // Bus cycles and comparison
  // ----------------------------------------
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] x);
    awaddr <= a;
    wdata <= {16'h0, x};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic [1:0] r = 2'h0);
    expQ.push_back({r, 24'h0, x});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    @(posedge clock);
  endtask
  always @(posedge clock) begin
    if (rvalid === 1'b1 && rready === 1'b1 && expQ.size() > 0) chk({rresp, rdata}, expQ.pop_front());
  end
  task automatic end_sim;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    end_sim();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'hcf6d36a9));
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd(8'h00, 8'h00);
    rd(8'h04, 8'h00);
    rd(8'h0c, 8'h00);
    rd(8'h20, 8'h00, 2'h2);
    $display("test reset done");
    d = $urandom;
    o = $urandom;
    wr(8'h00, d);
    wr(8'h04, o);
    @(negedge clock);
    chk({26'h0, pinOe}, {26'h0, d});
    chk({26'h0, pinOut}, {26'h0, o & d});
    t = $urandom;
    wr(8'h08, t);
    rd(8'h04, o ^ t);
    $display("test drive done");
    v = $urandom;
    wr(8'h00, 8'h00);
    ext <= v;
    repeat (6) @(posedge clock);
    rd(8'h08, v);
    wr(8'h14, 8'h04);
    ext <= ~v;
    repeat (6) @(posedge clock);
    rd(8'h08, {~v[7:1], v[0]});
    $display("test input done");
    ext <= 8'hff;
    wr(8'h14, 16'h0ad1);
    repeat (6) @(posedge clock);
    wr(8'h0c, 8'hff);
    rd(8'h0c, 8'h00);
    ext <= 8'h00;
    repeat (6) @(posedge clock);
    rd(8'h0c, 8'h0d);
    ext <= 8'hff;
    repeat (6) @(posedge clock);
    rd(8'h0c, 8'h0f);
    wr(8'h0c, 8'h0f);
    rd(8'h0c, 8'h00);
    ext <= 8'hf7;
    repeat (6) @(posedge clock);
    wr(8'h0c, 8'h08);
    rd(8'h0c, 8'h08);
    wr(8'h10, 8'h08);
    @(negedge clock);
    chk({33'h0, irq}, 34'h1);
    wr(8'h10, 8'h00);
    @(negedge clock);
    chk({33'h0, irq}, 34'h0);
    $display("test events done");
    wr(8'h1c, 8'h01);
    wr(8'h00, 8'h01);
    wr(8'h04, 8'h00);
    @(negedge clock);
    chk({26'h0, pinOut}, 34'h1);
    repeat (6) @(posedge clock);
    rd(8'h08, 8'hf6);
    $display("test swap done");
    end_sim();
  end
endmodule // gpio_port_fast_alias_tb
`default_nettype wire
